// [common/gtsec_consts.svh]
// Register offsets, field positions and reset values of the timer control block
`ifndef GTSEC_CONSTS_SVH
`define GTSEC_CONSTS_SVH
// ==========================================
// Register byte offsets
`define GTSEC_OFS_CTL0 8'h00
`define GTSEC_OFS_SMCFG 8'h08
`define GTSEC_OFS_CHCFG 8'h18
`define GTSEC_OFS_CNT 8'h24
`define GTSEC_OFS_CAR 8'h2c
`define GTSEC_OFS_CV 8'h34
`define GTSEC_OFS_DMACFG 8'h48
`define GTSEC_OFS_DMAWIN 8'h4c
`define GTSEC_OFS_DBG 8'h50
// ==========================================
// Field positions of the first control register
`define GTSEC_CTL0_CEN 0
`define GTSEC_CTL0_SPM 3
`define GTSEC_CTL0_DIR 4
`define GTSEC_CTL0_CAM_LO 5
`define GTSEC_CTL0_RELOAD_BUFFER_ENABLE 7
`define GTSEC_CTL0_SAMPLE_CLOCK_DIVIDER_LO 8
`define GTSEC_CTL0_MASK 16'h03ff
// Field positions of slave configuration
`define GTSEC_SM_SMC_LO 0
`define GTSEC_SM_TRIGGER_SOURCE_SELECT_LO 4
`define GTSEC_SM_EXT_TRIGGER_FILTER_CTL_LO 8
`define GTSEC_SM_EXT_TRIGGER_PRESCALE_LO 12
`define GTSEC_SM_ETP 15
`define GTSEC_SMCFG_MASK 16'hff77
// Field positions of channel configuration
`define GTSEC_CH_FLT_LO 0
`define GTSEC_CH_FEN 4
`define GTSEC_CH_MODE_LO 5
// Field positions of burst configuration
`define GTSEC_DMA_START_LO 0
`define GTSEC_DMA_LEN_LO 8
`define GTSEC_DMACFG_MASK 16'h1f1f
// ==========================================
// Reset values
`define GTSEC_RST_16 16'h0000
`define GTSEC_RST_CAR 16'hffff
`endif

// [common/gtsec_pkg.sv]
// Types shared by the timer control block
package gtsec_pkg;
   // ==========================================
   // Slave mode select encodings
   typedef enum logic [2:0] {
      GTSEC_SM_OFF = 3'h0,
      GTSEC_SM_ENC_A = 3'h1,
      GTSEC_SM_ENC_B = 3'h2,
      GTSEC_SM_ENC_AB = 3'h3,
      GTSEC_SM_RESTART = 3'h4,
      GTSEC_SM_PAUSE = 3'h5,
      GTSEC_SM_EVENT = 3'h6,
      GTSEC_SM_RSV = 3'h7
   } gtsec_smode_t;
   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } gtsec_bus_req_t;
   // Whole block state
   typedef struct packed {
      logic [15:0] ctl0;
      logic [15:0] smcfg;
      logic [7:0] chcfg;
      logic [15:0] cnt;
      logic [15:0] car_pre;
      logic [15:0] car_act;
      logic [15:0] cv;
      logic [15:0] dmacfg;
      logic freeze;
      logic [5:0] dma_left;
      logic [4:0] dma_idx;
      logic dma_req;
      logic [2:0] filt_out;
      logic [2:0][3:0] filt_cnt;
      logic fa_prev;
      logic fb_prev;
      logic trig_prev;
      logic ext_prev;
      logic [2:0] psc;
      logic [1:0] tick_cnt;
      logic oref;
      logic upd;
      logic [31:0] rdata;
   } gtsec_state_t;
endpackage : gtsec_pkg

// [dv/gtsec_checker.sv]
// Port-level assertions for the timer control block
`timescale 1ns/1ps
module gtsec_checker #(
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_we,
   input wire logic bus_re,
   input wire logic [31:0] bus_rdata,
   input wire logic quad_input_a,
   input wire logic quad_input_b,
   input wire logic [3:0] internal_trigger,
   input wire logic core_halted,
   input wire logic dma_event,
   input wire logic dma_req,
   input wire logic [CNT_W-1:0] count_value,
   input wire logic count_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Shadow copies of software settings
   logic [15:0] ctl_q; // Last control word written
   logic [15:0] sm_q; // Last slave configuration written
   logic frz_q; // Debug freeze bit
   logic [4:0] len_q; // Burst length field
   logic [5:0] left_q; // Burst requests still owed
   // Track writes; window accesses never aim at these in the bench
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_q <= 16'h0000;
         sm_q <= 16'h0000;
         frz_q <= 1'b0;
         len_q <= 5'h00;
         left_q <= 6'h00;
      end else begin
         if (bus_we && bus_addr == 8'h00) ctl_q <= bus_wdata[15:0];
         if (bus_we && bus_addr == 8'h08) sm_q <= bus_wdata[15:0];
         if (bus_we && bus_addr == 8'h50) frz_q <= bus_wdata[0];
         if (bus_we && bus_addr == 8'h48) len_q <= bus_wdata[12:8];
         // A new event restarts the whole sequence
         if (dma_event) left_q <= {1'b0, len_q} + 6'h01;
         else if ((bus_we || bus_re) && bus_addr == 8'h4c && left_q != 6'h00)
            left_q <= left_q - 6'h01;
      end
   end
   // ==========================================
   // Properties
   property p_rd_idle;
      !$past(bus_re) |-> bus_rdata == 32'h0;
   endproperty
   property p_ctl_rd;
      $past(bus_re) && $past(bus_addr) == 8'h00 |->
         bus_rdata[31:10] == 22'h0 && bus_rdata[9:5] == ctl_q[9:5];
   endproperty
   property p_dma_rise;
      dma_event |=> dma_req;
   endproperty
   property p_dma_track;
      dma_req == (left_q != 6'h00);
   endproperty
   property p_freeze;
      (core_halted && frz_q && !bus_we)[*3] |-> $stable(count_value);
   endproperty
   property p_restart;
      sm_q[2:0] == 3'h4 && sm_q[6:4] == 3'h0 && $rose(internal_trigger[0])
         |-> ##[1:5] count_value == '0;
   endproperty
   property p_pause;
      (sm_q[2:0] == 3'h5 && sm_q[6:4] == 3'h0 && !internal_trigger[0] && !bus_we)[*4]
         |-> $stable(count_value);
   endproperty
   property p_enc_up;
      sm_q[2:0] == 3'h1 && $rose(quad_input_a) && !quad_input_b |-> ##[1:8] !count_down;
   endproperty
   property p_enc_dn;
      sm_q[2:0] == 3'h1 && $fell(quad_input_a) && !quad_input_b |-> ##[1:8] count_down;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
   a_dma_rise: assert property (p_dma_rise) else $error("no burst request");
   a_dma_track: assert property (p_dma_track) else $error("burst count wrong");
   a_freeze: assert property (p_freeze) else $error("counter moved in halt");
   a_restart: assert property (p_restart) else $error("restart did not clear");
   a_pause: assert property (p_pause) else $error("counter moved in pause");
   a_enc_up: assert property (p_enc_up) else $error("encoder not up");
   a_enc_dn: assert property (p_enc_dn) else $error("encoder not down");
   c_burst: cover property (dma_event ##1 dma_req);
   c_dir: cover property ($rose(count_down));
   c_halt: cover property (core_halted && frz_q);
endmodule : gtsec_checker

// [dv/gtsec_enc_model.sv]
// Quadrature encoder source that steps its two phases on command
`timescale 1ns/1ps
module gtsec_enc_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic step,
   input wire logic fwd,
   output logic quad_input_a,
   output logic quad_input_b
);
   logic [1:0] ph_q; // Shaft position within one cycle of four
   // One edge per step; only one phase moves, as on a real shaft
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) ph_q <= 2'h0;
      else if (step) ph_q <= fwd ? ph_q + 2'h1 : ph_q - 2'h1;
   end
   // Forward order 00,10,11,01 lets input A lead, seen as up-counting
   assign quad_input_a = ph_q[0] ^ ph_q[1];
   assign quad_input_b = ph_q[1];
endmodule : gtsec_enc_model

// [dv/gtsec_tb_top.sv]
// Self-checking bench of the timer control block
`timescale 1ns/1ps
`define GTSEC_CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module gtsec_tb_top;
   localparam int CNT_W = 16;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} gtsec_row_t;
   logic clk = 0, resetn = 0, bus_we = 0, bus_re = 0, dma_event = 0, core_halted = 0;
   logic ext_trg = 0; // External trigger pin level
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0, bus_rdata, ra, rb;
   logic [3:0] internal_trigger = 4'h0;
   logic step = 0, fwd = 0, qa, qb, dma_req, count_down, update_pulse, oref;
   logic [CNT_W-1:0] count_value;
   int fail_count = 0, checked = 0, cyc = 0, upd_n = 0;
   gtsec_row_t rows [13] = '{
      '{8'h00, 32'hffff_fc80, 32'h80}, '{8'h00, 32'h200, 32'h200},
      '{8'h00, 32'h100, 32'h100}, '{8'h00, 32'h60, 32'h60}, '{8'h00, 32'h70, 32'h60},
      '{8'h00, 32'h10, 32'h0}, '{8'h00, 32'h10, 32'h10}, '{8'h08, 32'hffff, 32'hff77},
      '{8'h08, 32'h0, 32'h0}, '{8'h48, 32'hffff, 32'h1f1f}, '{8'h48, 32'h0, 32'h0},
      '{8'h04, 32'hffff, 32'h0}, '{8'h2c, 32'hffff_0007, 32'h7}};
   logic [2:0] emode [3] = '{3'h1, 3'h2, 3'h3};
   logic [31:0] einc [3] = '{32'h2, 32'h2, 32'h4};
   always #5 clk = ~clk;
   gtsec_top #(.CNT_W(CNT_W)) DUT (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata),
      .quad_input_a(qa), .quad_input_b(qb), .ext_trigger_in(ext_trg),
      .internal_trigger(internal_trigger), .core_halted(core_halted),
      .dma_event(dma_event), .dma_req(dma_req), .count_value(count_value),
      .count_down(count_down), .update_pulse(update_pulse), .channel_output_reference(oref));
   gtsec_enc_model u_enc (.clk(clk), .resetn(resetn), .step(step), .fwd(fwd),
      .quad_input_a(qa), .quad_input_b(qb));
   // ==========================================
   // Bus and stimulus tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_we <= 1'b1;
      @(posedge clk);
      bus_we <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge clk);
      bus_addr <= a;
      bus_re <= 1'b1;
      @(posedge clk);
      bus_re <= 1'b0;
      #1 r = bus_rdata;
   endtask : rd
   task automatic steps(input int n, input logic f);
      repeat (n) begin
         @(posedge clk);
         step <= 1'b1;
         fwd <= f;
         @(posedge clk);
         step <= 1'b0;
         repeat (12) @(posedge clk);
      end
   endtask : steps
   task automatic pulse_event();
      @(posedge clk);
      dma_event <= 1'b1;
      @(posedge clk);
      dma_event <= 1'b0;
      #1;
   endtask : pulse_event
   task automatic complete_run();
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // Hang guard and update counting
   always @(posedge clk) begin
      cyc++;
      if (update_pulse === 1'b1) upd_n++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h00, ra);
      `GTSEC_CHK(ra, 32'h0)
      rd(8'h2c, ra);
      `GTSEC_CHK(ra, 32'hffff)
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, ra);
         `GTSEC_CHK(ra, rows[i].e)
      end
      // Encoder modes; reload value of 7 was set first by the last row
      foreach (emode[i]) begin
         wr(8'h08, {29'h0, emode[i]});
         wr(8'h24, 32'h0);
         wr(8'h00, 32'h1);
         steps(4, 1'b1);
         rd(8'h24, ra);
         `GTSEC_CHK(ra, einc[i])
         `GTSEC_CHK(count_down, 1'b0)
         steps(4, 1'b0);
         rd(8'h24, ra);
         `GTSEC_CHK(ra, 32'h0)
         `GTSEC_CHK(count_down, 1'b1)
      end
      ra = upd_n;
      steps(1, 1'b0);
      rd(8'h24, rb);
      `GTSEC_CHK(rb, 32'h7)
      `GTSEC_CHK(upd_n > ra, 1'b1)
      // Burst window writes land on counter, a hole and reload
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h48, 32'h0209);
      pulse_event();
      `GTSEC_CHK(dma_req, 1'b1)
      wr(8'h4c, 32'h1234);
      wr(8'h4c, 32'h5555);
      wr(8'h4c, 32'h0005);
      #1 `GTSEC_CHK(dma_req, 1'b0)
      rd(8'h24, ra);
      `GTSEC_CHK(ra, 32'h1234)
      rd(8'h2c, ra);
      `GTSEC_CHK(ra, 32'h5)
      wr(8'h48, 32'h0009);
      pulse_event();
      rd(8'h4c, ra);
      `GTSEC_CHK(ra, 32'h1234)
      `GTSEC_CHK(dma_req, 1'b0)
      // One-shot stops at update and reinitialises
      wr(8'h2c, 32'h5);
      wr(8'h00, 32'h9);
      repeat (20) @(posedge clk);
      rd(8'h00, ra);
      `GTSEC_CHK(ra, 32'h8)
      rd(8'h24, ra);
      `GTSEC_CHK(ra, 32'h0)
      wr(8'h2c, 32'hffff);
      wr(8'h00, 32'h9);
      repeat (10) @(posedge clk);
      wr(8'h00, 32'h8);
      rd(8'h24, ra);
      repeat (5) @(posedge clk);
      rd(8'h24, rb);
      `GTSEC_CHK(rb, ra)
      // Restart, pause and event on internal trigger zero
      wr(8'h08, 32'h4);
      wr(8'h00, 32'h1);
      repeat (30) @(posedge clk);
      internal_trigger <= 4'h1;
      repeat (4) @(posedge clk);
      rd(8'h24, ra);
      `GTSEC_CHK(ra < 32'd10, 1'b1)
      internal_trigger <= 4'h0;
      wr(8'h08, 32'h5);
      repeat (6) @(posedge clk);
      rd(8'h24, ra);
      repeat (10) @(posedge clk);
      rd(8'h24, rb);
      `GTSEC_CHK(rb, ra)
      internal_trigger <= 4'h1;
      repeat (10) @(posedge clk);
      rd(8'h24, rb);
      `GTSEC_CHK(rb > ra, 1'b1)
      internal_trigger <= 4'h0;
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h6);
      repeat (6) @(posedge clk);
      internal_trigger <= 4'h1;
      repeat (8) @(posedge clk);
      rd(8'h00, ra);
      `GTSEC_CHK(ra[0], 1'b1)
      // Debug halt with freeze set holds the count
      internal_trigger <= 4'h0;
      wr(8'h08, 32'h0);
      wr(8'h50, 32'h1);
      wr(8'h00, 32'h1);
      core_halted <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h24, ra);
      repeat (5) @(posedge clk);
      rd(8'h24, rb);
      `GTSEC_CHK(rb, ra)
      core_halted <= 1'b0;
      repeat (5) @(posedge clk);
      rd(8'h24, rb);
      `GTSEC_CHK(rb != ra, 1'b1)
      // Fast enable forces the post-match level on a one-shot trigger
      wr(8'h00, 32'h0);
      wr(8'h24, 32'h0);
      wr(8'h34, 32'h10);
      wr(8'h18, 32'hd0);
      wr(8'h08, 32'h6);
      wr(8'h00, 32'h8);
      #1 `GTSEC_CHK(oref, 1'b1)
      @(posedge clk);
      internal_trigger <= 4'h1;
      @(posedge clk);
      #1 `GTSEC_CHK(oref, 1'b0)
      // External trigger through filter and divide-by-two prescaler
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h1076);
      ext_trg <= 1'b1;
      repeat (6) @(posedge clk);
      rd(8'h00, ra);
      `GTSEC_CHK(ra[0], 1'b1)
      complete_run();
   end
endmodule : gtsec_tb_top
bind gtsec_top gtsec_checker #(.CNT_W(CNT_W)) u_chk (.clk(clk), .resetn(resetn),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
   .bus_rdata(bus_rdata), .quad_input_a(quad_input_a), .quad_input_b(quad_input_b),
   .internal_trigger(internal_trigger), .core_halted(core_halted), .dma_event(dma_event),
   .dma_req(dma_req), .count_value(count_value), .count_down(count_down));

// [rtl/gtsec_top.sv]
// Timer slave controller, encoder counting, one-shot and burst window
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "gtsec_consts.svh"

// Overview of operation
// - Slave mode 1/2/3 picks encoder source
// - Encoder edges set direction bit by hardware
// - Encoder counts between zero and reload
// - Edge and level table decides up/down
// - Modes 4/5/6 are restart, pause, event
// - Trigger select picks internal, channel, external
// - Filters and prescaler per trigger class
// - Restart clears counter on trigger rise
// - Pause holds counter while trigger low
// - Event mode starts counter on rise
// - One-shot stops counter at update
// - Run write or trigger starts pulse
// - Software stop holds, hardware stop reinitialises
// - Fast enable forces post-match reference
// - Burst window redirects to indexed register
// - Length plus one requests, stepping by four
// - Debug halt with freeze stops counter
// - Clock divider sets filter sample tick
// - Reload buffer enable selects shadowed reload
// - Alignment mode edge or center variants
// - Direction read-only in center or encoder
module gtsec_top #(
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_we,
   input wire logic bus_re,
   output logic [31:0] bus_rdata,
   input wire logic quad_input_a,
   input wire logic quad_input_b,
   input wire logic ext_trigger_in,
   input wire logic [3:0] internal_trigger,
   input wire logic core_halted,
   input wire logic dma_event,
   output logic dma_req,
   output logic [CNT_W-1:0] count_value,
   output logic count_down,
   output logic update_pulse,
   output logic channel_output_reference
);

   // ==========================================
   // Helper functions

   // Filter length per filter code; 0 passes at the first sample
   function automatic logic [3:0] filt_len(input logic [3:0] code);
      logic [3:0] n;
      n = 4'h8;
      case (code)
         4'h0: n = 4'h1;
         4'h1: n = 4'h2;
         4'h2: n = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hb, 4'he: n = 4'h6;
         4'ha, 4'hd: n = 4'h5;
         default: n = 4'h8;
      endcase
      return n;
   endfunction : filt_len

   // One count step with wrap; bit 16 flags the update event
   function automatic logic [16:0] step(input logic [15:0] c, input logic [15:0] top,
                                        input logic up);
      logic [16:0] r;
      r = {1'b0, c};
      if (up) begin
         r = (c >= top) ? 17'h10000 : {1'b0, c + 16'h0001};
      end else begin
         r = (c == 16'h0000) ? {1'b1, top} : {1'b0, c - 16'h0001};
      end
      return r;
   endfunction : step

   // Register write; ofs is already resolved past the burst window
   function automatic gtsec_pkg::gtsec_state_t reg_wr(input gtsec_pkg::gtsec_state_t st,
                                                      input logic [7:0] ofs,
                                                      input logic [15:0] d,
                                                      input logic dir_ro);
      gtsec_pkg::gtsec_state_t r;
      r = st;
      case (ofs)
         `GTSEC_OFS_CTL0: begin
            r.ctl0 = d & `GTSEC_CTL0_MASK;
            // Direction stays hardware owned in center or encoder mode
            if (dir_ro) begin
               r.ctl0[`GTSEC_CTL0_DIR] = st.ctl0[`GTSEC_CTL0_DIR];
            end
         end
         `GTSEC_OFS_SMCFG: r.smcfg = d & `GTSEC_SMCFG_MASK;
         `GTSEC_OFS_CHCFG: r.chcfg = d[7:0];
         `GTSEC_OFS_CNT: r.cnt = d;
         `GTSEC_OFS_CAR: begin
            r.car_pre = d;
            // Unbuffered reload takes effect at once
            if (!st.ctl0[`GTSEC_CTL0_RELOAD_BUFFER_ENABLE]) begin
               r.car_act = d;
            end
         end
         `GTSEC_OFS_CV: r.cv = d;
         `GTSEC_OFS_DMACFG: r.dmacfg = d & `GTSEC_DMACFG_MASK;
         `GTSEC_OFS_DBG: r.freeze = d[0];
         default: r = st; // Unmapped writes are dropped
      endcase
      return r;
   endfunction : reg_wr

   // Register read; unmapped offsets read zero
   function automatic logic [15:0] reg_rd(input gtsec_pkg::gtsec_state_t st,
                                          input logic [7:0] ofs);
      logic [15:0] v;
      v = 16'h0000;
      case (ofs)
         `GTSEC_OFS_CTL0: v = st.ctl0;
         `GTSEC_OFS_SMCFG: v = st.smcfg;
         `GTSEC_OFS_CHCFG: v = {8'h00, st.chcfg};
         `GTSEC_OFS_CNT: v = st.cnt;
         `GTSEC_OFS_CAR: v = st.car_pre;
         `GTSEC_OFS_CV: v = st.cv;
         `GTSEC_OFS_DMACFG: v = st.dmacfg;
         `GTSEC_OFS_DBG: v = {15'h0000, st.freeze};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : reg_rd

   // ==========================================
   // State
   gtsec_pkg::gtsec_state_t state_q; // All registered state
   gtsec_pkg::gtsec_state_t state_d; // Next state
   gtsec_pkg::gtsec_bus_req_t req; // Bus request bundle

   assign req = '{addr: bus_addr, wdata: bus_wdata, we: bus_we, re: bus_re};

   // ==========================================
   // Next-state logic
   always_comb begin
      gtsec_pkg::gtsec_smode_t smode;
      logic [2:0] raw;
      logic [3:0] n;
      logic [3:0] code;
      logic tick;
      logic fa;
      logic fb;
      logic a_edge;
      logic b_edge;
      logic ext_lv;
      logic ext_p;
      logic trig;
      logic trig_rise;
      logic enc;
      logic dir_ro;
      logic halt;
      logic run;
      logic up;
      logic [16:0] st;
      logic [7:0] ofs;
      logic win;
      logic pwm;
      logic [2:0] mode;
      smode = gtsec_pkg::gtsec_smode_t'(state_q.smcfg[2:0]);
      raw = 3'h0;
      n = 4'h1;
      code = 4'h0;
      tick = 1'b0;
      up = 1'b0;
      st = 17'h00000;
      fa = 1'b0;
      fb = 1'b0;
      a_edge = 1'b0;
      b_edge = 1'b0;
      ext_lv = 1'b0;
      ext_p = 1'b0;
      trig = 1'b0;
      trig_rise = 1'b0;
      enc = 1'b0;
      dir_ro = 1'b0;
      halt = 1'b0;
      run = 1'b0;
      ofs = 8'h00;
      win = 1'b0;
      pwm = 1'b0;
      mode = 3'h0;
      state_d = state_q;
      state_d.upd = 1'b0;
      state_d.rdata = 32'h00000000;

      // Sample tick divider: 1, 2 or 4 kernel cycles; the reserved code runs at 1
      state_d.tick_cnt = state_q.tick_cnt + 2'h1;
      case (state_q.ctl0[9:8])
         2'h1: tick = state_q.tick_cnt[0];
         2'h2: tick = (state_q.tick_cnt == 2'h3);
         default: tick = 1'b1;
      endcase

      // Digital filters: channels use the capture setting, external its own
      raw = {ext_trigger_in ^ state_q.smcfg[`GTSEC_SM_ETP], quad_input_b, quad_input_a};
      for (int i = 0; i < 3; i++) begin
         code = (i == 2) ? state_q.smcfg[11:8] : state_q.chcfg[3:0];
         n = filt_len(code);
         if (tick) begin
            if (raw[i] == state_q.filt_out[i]) begin
               state_d.filt_cnt[i] = 4'h0;
            end else if (state_q.filt_cnt[i] + 4'h1 >= n) begin
               // Input stable for N samples: pass it on
               state_d.filt_out[i] = raw[i];
               state_d.filt_cnt[i] = 4'h0;
            end else begin
               state_d.filt_cnt[i] = state_q.filt_cnt[i] + 4'h1;
            end
         end
      end

      // Edge detection on filtered channel inputs
      fa = state_q.filt_out[0];
      fb = state_q.filt_out[1];
      a_edge = fa ^ state_q.fa_prev;
      b_edge = fb ^ state_q.fb_prev;
      state_d.fa_prev = fa;
      state_d.fb_prev = fb;

      // External trigger prescaler counts active edges only
      ext_lv = state_q.filt_out[2];
      state_d.ext_prev = ext_lv;
      if (ext_lv && !state_q.ext_prev) begin
         state_d.psc = state_q.psc + 3'h1;
      end
      case (state_q.smcfg[13:12])
         2'h1: ext_p = state_q.psc[0];
         2'h2: ext_p = state_q.psc[1];
         2'h3: ext_p = state_q.psc[2];
         default: ext_p = ext_lv;
      endcase

      // Trigger source select; internal triggers bypass filter and prescaler
      case (state_q.smcfg[6:4])
         3'h0, 3'h1, 3'h2, 3'h3: trig = internal_trigger[state_q.smcfg[5:4]];
         3'h4: trig = a_edge;
         3'h5: trig = fa;
         3'h6: trig = fb;
         default: trig = ext_p;
      endcase
      state_d.trig_prev = trig;
      trig_rise = trig && !state_q.trig_prev;

      enc = (smode == gtsec_pkg::GTSEC_SM_ENC_A) || (smode == gtsec_pkg::GTSEC_SM_ENC_B)
            || (smode == gtsec_pkg::GTSEC_SM_ENC_AB);
      dir_ro = enc || (state_q.ctl0[6:5] != 2'h0);

      // ==========================================
      // Register bus; the burst window maps onto start index plus four per step
      win = (req.addr == `GTSEC_OFS_DMAWIN);
      ofs = win ? 8'({state_q.dmacfg[4:0] + state_q.dma_idx, 2'b00}) : req.addr;
      if (req.we) begin
         state_d = reg_wr(state_d, ofs, req.wdata[15:0], dir_ro);
      end
      if (req.re) begin
         state_d.rdata = {16'h0000, reg_rd(state_q, ofs)};
      end

      // Burst sequencer: a fresh event restarts the whole sequence
      if (dma_event) begin
         state_d.dma_left = 6'(state_q.dmacfg[12:8]) + 6'h01;
         state_d.dma_idx = 5'h00;
         state_d.dma_req = 1'b1;
      end else if (win && (req.we || req.re) && state_q.dma_left != 6'h00) begin
         state_d.dma_left = state_q.dma_left - 6'h01;
         state_d.dma_idx = state_q.dma_idx + 5'h01;
         state_d.dma_req = (state_q.dma_left != 6'h01);
      end

      // ==========================================
      // Counter core
      halt = core_halted && state_q.freeze;
      // Event mode and one-shot trigger start; set beats a same-cycle software clear
      if (trig_rise && (smode == gtsec_pkg::GTSEC_SM_EVENT)) begin
         state_d.ctl0[`GTSEC_CTL0_CEN] = 1'b1;
      end
      if (trig_rise && state_q.ctl0[`GTSEC_CTL0_SPM] && !enc) begin
         state_d.ctl0[`GTSEC_CTL0_CEN] = 1'b1;
      end
      run = state_q.ctl0[`GTSEC_CTL0_CEN] && !halt;

      if (enc) begin
         // Direction follows the edge against the other input level
         if (run && a_edge && (smode != gtsec_pkg::GTSEC_SM_ENC_B)) begin
            up = fa ^ fb;
            st = step(state_q.cnt, state_q.car_act, up);
            state_d.cnt = st[15:0];
            state_d.upd = st[16];
            state_d.ctl0[`GTSEC_CTL0_DIR] = !up;
         end else if (run && b_edge && (smode != gtsec_pkg::GTSEC_SM_ENC_A)) begin
            up = fa ~^ fb;
            st = step(state_q.cnt, state_q.car_act, up);
            state_d.cnt = st[15:0];
            state_d.upd = st[16];
            state_d.ctl0[`GTSEC_CTL0_DIR] = !up;
         end
      end else if (trig_rise && (smode == gtsec_pkg::GTSEC_SM_RESTART)) begin
         // Restart clears and raises a slave update event
         state_d.cnt = 16'h0000;
         state_d.upd = 1'b1;
      end else if (run && !((smode == gtsec_pkg::GTSEC_SM_PAUSE) && !trig)) begin
         up = !state_q.ctl0[`GTSEC_CTL0_DIR];
         st = step(state_q.cnt, state_q.car_act, up);
         if (state_q.ctl0[6:5] != 2'h0) begin
            // Center-aligned: turn round at the ends instead of wrapping
            if (up && state_q.cnt >= state_q.car_act) begin
               st = {1'b1, state_q.cnt - 16'h0001};
               state_d.ctl0[`GTSEC_CTL0_DIR] = 1'b1;
            end else if (!up && state_q.cnt == 16'h0000) begin
               st = 17'h10001;
               state_d.ctl0[`GTSEC_CTL0_DIR] = 1'b0;
            end
         end
         state_d.cnt = st[15:0];
         state_d.upd = st[16];
      end

      // Update event: load shadow, end a one-shot pulse
      if (state_d.upd) begin
         if (state_q.ctl0[`GTSEC_CTL0_RELOAD_BUFFER_ENABLE]) begin
            state_d.car_act = state_q.car_pre;
         end
         if (state_q.ctl0[`GTSEC_CTL0_SPM]) begin
            state_d.ctl0[`GTSEC_CTL0_CEN] = 1'b0;
            // Hardware stop reinitialises; a software stop never reaches here
            state_d.cnt = state_d.ctl0[`GTSEC_CTL0_DIR] ? state_q.car_act : 16'h0000;
         end
      end

      // ==========================================
      // Output reference of the channel
      mode = state_q.chcfg[7:5];
      pwm = (mode == 3'h6) || (mode == 3'h7);
      case (mode)
         3'h1: if (state_q.cnt == state_q.cv) state_d.oref = 1'b1;
         3'h2: if (state_q.cnt == state_q.cv) state_d.oref = 1'b0;
         3'h3: if (state_q.cnt == state_q.cv) state_d.oref = !state_q.oref;
         3'h4: state_d.oref = 1'b0;
         3'h5: state_d.oref = 1'b1;
         3'h6: state_d.oref = (state_q.cnt < state_q.cv);
         3'h7: state_d.oref = !(state_q.cnt < state_q.cv);
         default: state_d.oref = state_q.oref;
      endcase
      // Fast enable skips the compare latency on a one-shot trigger
      if (trig_rise && pwm && state_q.chcfg[`GTSEC_CH_FEN] && state_q.ctl0[`GTSEC_CTL0_SPM]) begin
         state_d.oref = (mode == 3'h7);
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= '0;
         state_q.car_pre <= `GTSEC_RST_CAR;
         state_q.car_act <= `GTSEC_RST_CAR;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================
   // Outputs straight from flip-flops
   assign bus_rdata = state_q.rdata;
   assign dma_req = state_q.dma_req;
   assign count_value = CNT_W'(state_q.cnt);
   assign count_down = state_q.ctl0[`GTSEC_CTL0_DIR];
   assign update_pulse = state_q.upd;
   assign channel_output_reference = state_q.oref;

endmodule : gtsec_top
